// ==== design/msac_sar.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Successive approximation register, one bit per step from the top down.
// ==========================================================================
module msac_sar import msac_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control from the sequencer, and the synchronised comparator.
  input wire logic init_i,
  input wire logic step_i,
  input wire logic keep_i,
  // Trial code driven to the DAC, final result after the last step.
  output logic [RES_W-1:0] code_o
);

  logic [RES_W-1:0] mask_r;

  // Each step keeps or drops the bit under trial and tries the next lower one.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      code_o <= RESULT_RST;
      mask_r <= RESULT_RST;
    end else if (init_i) begin
      code_o <= SAR_MSB;
      mask_r <= SAR_MSB;
    end else if (step_i) begin
      code_o <= (keep_i ? code_o : (code_o & ~mask_r)) | (mask_r >> 1);
      mask_r <= mask_r >> 1;
    end
  end

  // The trial pointer is one-hot while resolving and empty once done.
  property p_mask_onehot;
    @(posedge clk_i) disable iff (!nrst_i) $onehot0(mask_r);
  endproperty
  a_mask_onehot: assert property (p_mask_onehot) else $error("SAR trial mask not one-hot");

  // A dropped trial bit really clears while the next one is set.
  property p_step_decides;
    @(posedge clk_i) disable iff (!nrst_i)
      (step_i && !init_i && !keep_i && (mask_r != 14'h0000)) |=> ((code_o & $past(mask_r)) == 14'h0000);
  endproperty
  a_step_decides: assert property (p_step_decides) else $error("SAR kept a rejected bit");

endmodule // msac_sar

// ==== design/msac_sync.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Two-flop synchroniser for pins from outside the clock domain.
// ==========================================================================
module msac_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Asynchronous pins and their synchronised copy.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage, to contain metastability.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // msac_sync

// ==== design/msac_top.sv ====
`timescale 1ns/10ps
module msac_top import msac_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Host control pins.
  input wire logic conv_clk_i,
  input wire logic start_convert_pulse_i,
  input wire logic [CHAN_W-1:0] chan_addr_i,
  input wire logic mux_enable_i,
  input wire logic output_enable_i,
  // Analog comparator: high when the held input is above the DAC trial.
  input wire logic comp_above_i,
  // Status pins.
  output logic busy_n_o,
  output logic eoc_o,
  // Result bus, to be tri-stated by the pad while result_oe_n_o is high.
  output logic [RES_W-1:0] result_o,
  output logic result_oe_n_o,
  // Analog front end control.
  output logic [CHAN_W-1:0] mux_chan_o,
  output logic mux_en_o,
  output logic sample_o,
  output logic [RES_W-1:0] dac_code_o
);

  // ========================================================================
  // Pin synchronisation and edge detection
  // ========================================================================
  logic [SYNC_W-1:0] pins_sync;
  logic conv_clk_s;
  logic start_s;
  logic [CHAN_W-1:0] addr_s;
  logic en_s;
  logic oe_s;
  logic comp_s;
  logic conv_clk_prev_r;
  logic start_prev_r;
  logic conv_edge;
  logic start_edge;

  // All host pins are asynchronous to clk_i, so they share one synchroniser.
  msac_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({conv_clk_i, start_convert_pulse_i, chan_addr_i, mux_enable_i, output_enable_i, comp_above_i}),
    .sync_o(pins_sync)
  );

  // Unpack the synchronised pins.
  assign {conv_clk_s, start_s, addr_s, en_s, oe_s, comp_s} = pins_sync;

  // Previous values for edge detection on the converter clock and start.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      conv_clk_prev_r <= 1'b0;
      start_prev_r <= 1'b0;
    end else begin
      conv_clk_prev_r <= conv_clk_s;
      start_prev_r <= start_s;
    end
  end

  // Start is acted on by its rising edge, so a level held high starts nothing more.
  assign conv_edge = conv_clk_s & ~conv_clk_prev_r;
  assign start_edge = start_s & ~start_prev_r;

  // ========================================================================
  // Sequencer
  // ========================================================================
  msac_state_t state_r;
  logic [STEP_W-1:0] step_r;
  logic [STEP_W-1:0] step_nxt;
  logic first_edge;
  logic sar_init;
  logic sar_step;
  logic load;
  logic [RES_W-1:0] sar_code;

  // Periods elapsed since the first edge, counted on converter clock edges.
  assign step_nxt = step_r + 5'h01;
  assign first_edge = (state_r == MSAC_ARMED) && conv_edge;
  assign sar_init = (state_r == MSAC_CONV) && conv_edge && (step_nxt == SAMPLE_PERIODS);
  assign sar_step = (state_r == MSAC_CONV) && conv_edge && (step_nxt >= SAR_FIRST_STEP)
                    && (step_nxt <= SAR_LAST_STEP);
  assign load = (state_r == MSAC_CONV) && conv_edge && (step_nxt == CONV_PERIODS);

  // A start edge arms the cycle; the next converter clock edge is its first.
  // Starts seen while armed or converting are ignored, one request, one result.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= MSAC_IDLE;
    end else begin
      case (state_r)
        MSAC_IDLE: begin
          if (start_edge) begin
            state_r <= MSAC_ARMED;
          end
        end
        MSAC_ARMED: begin
          if (conv_edge) begin
            state_r <= MSAC_CONV;
          end
        end
        MSAC_CONV: begin
          if (load) begin
            state_r <= MSAC_IDLE;
          end
        end
        default: begin
          state_r <= MSAC_IDLE;
        end
      endcase
    end
  end

  // Step count restarts at the first edge and advances once per period.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      step_r <= STEP_RST;
    end else if (first_edge) begin
      step_r <= STEP_RST;
    end else if ((state_r == MSAC_CONV) && conv_edge) begin
      step_r <= step_nxt;
    end
  end

  // ========================================================================
  // Front end control: multiplexer, sample gate, approximation
  // ========================================================================

  // The address is latched once, so a host change mid-cycle cannot corrupt the sample.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mux_chan_o <= CHAN_RST;
    end else if (first_edge) begin
      mux_chan_o <= addr_s;
    end
  end

  // The multiplexer enable follows its pin; with it low no channel is routed.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mux_en_o <= 1'b0;
    end else begin
      mux_en_o <= en_s;
    end
  end

  // Track from the first edge until three periods have passed, then hold.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sample_o <= 1'b0;
    end else if (first_edge) begin
      sample_o <= 1'b1;
    end else if (sar_init) begin
      sample_o <= 1'b0;
    end
  end

  // The approximation register drives the DAC trial code directly.
  msac_sar u_sar (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .init_i(sar_init),
    .step_i(sar_step),
    .keep_i(comp_s),
    .code_o(sar_code)
  );

  assign dac_code_o = sar_code;

  // ========================================================================
  // Result and status
  // ========================================================================

  // The result only moves at completion, so a reader never sees a partial code.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      result_o <= RESULT_RST;
    end else if (load) begin
      result_o <= sar_code;
    end
  end

  // Busy drops at the first edge and rises with the new result.
  // In continuous mode that rise is the next start edge, costing one extra period per cycle.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_n_o <= 1'b1;
    end else if (load) begin
      busy_n_o <= 1'b1;
    end else if (first_edge) begin
      busy_n_o <= 1'b0;
    end
  end

  // End of conversion marks a fresh result until the next cycle begins.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      eoc_o <= 1'b0;
    end else if (load) begin
      eoc_o <= 1'b1;
    end else if (first_edge) begin
      eoc_o <= 1'b0;
    end
  end

  // The pad drives the bus only while the host enables it, so buses can be shared.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      result_oe_n_o <= 1'b1;
    end else begin
      result_oe_n_o <= ~oe_s;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================

  // Result moves only on the completion pulse.
  property p_result_on_load;
    @(posedge clk_i) disable iff (!nrst_i) $changed(result_o) |-> $past(load);
  endproperty
  a_result_on_load: assert property (p_result_on_load) else $error("Result changed without completion");

  // While busy is high the result is stable.
  property p_result_valid_idle;
    @(posedge clk_i) disable iff (!nrst_i) ($past(busy_n_o) && busy_n_o) |-> $stable(result_o);
  endproperty
  a_result_valid_idle: assert property (p_result_valid_idle) else $error("Result moved while idle");

  // Completion comes exactly at the twentieth period.
  property p_conv_length;
    @(posedge clk_i) disable iff (!nrst_i) load |-> (step_r == CONV_PERIODS - 5'h01) && (state_r == MSAC_CONV);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("Conversion length not twenty periods");

  // Busy is low exactly while a conversion is in progress.
  property p_busy_level;
    @(posedge clk_i) disable iff (!nrst_i) (state_r == MSAC_CONV) |-> ##1 (!busy_n_o || $past(load));
  endproperty
  a_busy_level: assert property (p_busy_level) else $error("Busy high during conversion");

  // End of conversion rises together with busy at completion.
  property p_eoc_with_load;
    @(posedge clk_i) disable iff (!nrst_i) $rose(eoc_o) |-> $past(load) && busy_n_o;
  endproperty
  a_eoc_with_load: assert property (p_eoc_with_load) else $error("End of conversion without result");

  // The channel is held for the whole cycle.
  property p_addr_held;
    @(posedge clk_i) disable iff (!nrst_i) (!busy_n_o && !$past(first_edge)) |-> $stable(mux_chan_o);
  endproperty
  a_addr_held: assert property (p_addr_held) else $error("Channel changed mid-cycle");

  // Sampling covers only the first three periods.
  property p_sample_window;
    @(posedge clk_i) disable iff (!nrst_i) sample_o |-> (step_r < SAMPLE_PERIODS) && (state_r == MSAC_CONV);
  endproperty
  a_sample_window: assert property (p_sample_window) else $error("Sampling outside first periods");

  // The bus enable follows the synchronised pin one clock later.
  property p_oe_follow;
    @(posedge clk_i) disable iff (!nrst_i) oe_s |=> !result_oe_n_o;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("Bus not driven when enabled");

  // A start edge while idle arms a conversion on the next clock.
  property p_start_arms;
    @(posedge clk_i) disable iff (!nrst_i) (start_edge && (state_r == MSAC_IDLE)) |=> (state_r == MSAC_ARMED);
  endproperty
  a_start_arms: assert property (p_start_arms) else $error("Start request lost");

  // Multiplexer enable tracks its pin.
  property p_mux_en;
    @(posedge clk_i) disable iff (!nrst_i) ##1 (mux_en_o == $past(en_s));
  endproperty
  a_mux_en: assert property (p_mux_en) else $error("Multiplexer enable not following pin");

  // Main scenarios.
  c_single: cover property (@(posedge clk_i) disable iff (!nrst_i) load ##1 (state_r == MSAC_IDLE));
  c_back_to_back: cover property (@(posedge clk_i) disable iff (!nrst_i) load ##[1:40] first_edge);
  c_read_bus: cover property (@(posedge clk_i) disable iff (!nrst_i) eoc_o && !result_oe_n_o);
  c_start_busy: cover property (@(posedge clk_i) disable iff (!nrst_i) start_edge && (state_r == MSAC_CONV));

endmodule // msac_top

// ==== include/msac_pkg.sv ====
// ==========================================================================
// Shared constants for the multiplexed converter sequencer.
// ==========================================================================
package msac_pkg;

  // Channel address and result widths.
  localparam int CHAN_W = 3;
  localparam int RES_W = 14;

  // Step counter width, wide enough for a full conversion cycle.
  localparam int STEP_W = 5;

  // Cycle shape in converter clock periods, counted from the first edge.
  localparam logic [STEP_W-1:0] CONV_PERIODS = 5'h14;
  localparam logic [STEP_W-1:0] SAMPLE_PERIODS = 5'h03;
  localparam logic [STEP_W-1:0] SAR_FIRST_STEP = SAMPLE_PERIODS + 5'h01;
  localparam logic [STEP_W-1:0] SAR_LAST_STEP = SAMPLE_PERIODS + 5'h0e;

  // Pin synchroniser width: converter clock, start, address, enable, output enable, comparator.
  localparam int SYNC_W = CHAN_W + 5;

  // Values after reset, and the first SAR trial code.
  localparam logic [RES_W-1:0] RESULT_RST = 14'h0000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [STEP_W-1:0] STEP_RST = 5'h00;
  localparam logic [RES_W-1:0] SAR_MSB = 14'h2000;

  // Sequencer states.
  typedef enum logic [1:0] {
    MSAC_IDLE,
    MSAC_ARMED,
    MSAC_CONV
  } msac_state_t;

endpackage

// ==== tb/msac_host.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Host side: converter clock, start pin and an ideal analog front end.
// ==========================================================================
module msac_host import msac_pkg::*; #(
  parameter int HALF = 5
) (
  // System clock and the mode chosen by the bench.
  input wire logic clk_i,
  input wire logic cont_i,
  // Signals seen from the block, and the analog inputs.
  input wire logic busy_n_i,
  input wire logic sample_i,
  input wire logic [CHAN_W-1:0] chan_i,
  input wire logic [RES_W-1:0] dac_code_i,
  input wire logic [RES_W-1:0] ain_i [8],
  // Pins driven toward the block.
  output logic conv_clk_o,
  output logic start_o,
  output logic comp_above_o
);
  logic pulse_r = 1'b0;
  logic [RES_W-1:0] held_r = '0;
  int div_r = 0;
  initial conv_clk_o = 1'b0;

  // Free-running converter clock, HALF system clocks per half period.
  always @(posedge clk_i) begin
    if (div_r == HALF - 1) begin
      div_r <= 0;
      conv_clk_o <= ~conv_clk_o;
    end else begin
      div_r <= div_r + 1;
    end
  end

  // Continuous mode loops busy back to start, so every completion retriggers.
  assign start_o = cont_i ? busy_n_i : pulse_r;

  // A short pulse, never a static level on the start pin.
  task automatic kick();
    @(posedge clk_i);
    pulse_r <= 1'b1;
    repeat (8) @(posedge clk_i);
    pulse_r <= 1'b0;
  endtask

  // Track while the gate is open, hold afterwards.
  always @(posedge clk_i) begin
    if (sample_i) begin
      held_r <= ain_i[chan_i];
    end
  end

  // Input sits half a step above its code, so ties never arise.
  assign comp_above_o = {held_r, 1'b1} > {dac_code_i, 1'b0};
endmodule // msac_host

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the converter sequencer.
// ==========================================================================
module tb_top import msac_pkg::*; ;
  localparam int HALF = 5;
  localparam int W = RES_W;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [CHAN_W-1:0] chan_addr_i = CHAN_RST;
  logic mux_enable_i = 1'b1;
  logic output_enable_i = 1'b0;
  logic cont = 1'b0;
  logic conv_clk, start, comp_above;
  logic busy_n_o, eoc_o, result_oe_n_o, mux_en_o, sample_o;
  logic [RES_W-1:0] result_o, dac_code_o;
  logic [CHAN_W-1:0] mux_chan_o;
  logic [RES_W-1:0] ain [8] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff, 14'h0001, 14'h2aaa, 14'h1555, 14'h3ffe};
  int n_mismatch = 0;
  int checks = 0;

  always #4 clk_i = ~clk_i;

  // ==========================================================================
  // Device and host.
  // ==========================================================================
  msac_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .conv_clk_i(conv_clk), .start_convert_pulse_i(start),
    .chan_addr_i(chan_addr_i), .mux_enable_i(mux_enable_i), .output_enable_i(output_enable_i),
    .comp_above_i(comp_above), .busy_n_o(busy_n_o), .eoc_o(eoc_o), .result_o(result_o),
    .result_oe_n_o(result_oe_n_o), .mux_chan_o(mux_chan_o), .mux_en_o(mux_en_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o));
  msac_host #(.HALF(HALF)) host (.clk_i(clk_i), .cont_i(cont), .busy_n_i(busy_n_o), .sample_i(sample_o),
    .chan_i(mux_chan_o), .dac_code_i(dac_code_o), .ain_i(ain), .conv_clk_o(conv_clk), .start_o(start),
    .comp_above_o(comp_above));

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Outputs are read 1 ns after the edge, once its updates have landed.
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_busy(input logic v, output int n);
    n = 0;
    while (busy_n_o !== v && n < 500) begin
      tick();
      n++;
    end
    if (n == 500) chk(W'(0), W'(1), "busy wait");
  endtask

  task automatic give_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_reset();
    tick();
    chk(W'(busy_n_o), W'(1), "busy idle");
    chk(W'(eoc_o), W'(0), "eoc idle");
    chk(result_o, RESULT_RST, "result reset");
    chk(W'(result_oe_n_o), W'(1), "bus released");
    $display("test reset done");
  endtask

  // One conversion; with again set, a second start mid-cycle must be ignored.
  task automatic t_single(input logic [CHAN_W-1:0] ch, input bit again);
    logic [RES_W-1:0] prev;
    int n;
    int s;
    bit moved;
    prev = result_o;
    s = 0;
    moved = 1'b0;
    @(posedge clk_i);
    chan_addr_i <= ch;
    fork host.kick(); join_none
    wait_busy(1'b0, n);
    chk(W'(eoc_o), W'(0), "eoc at start");
    n = 0;
    while (busy_n_o === 1'b0 && n < 400) begin
      // The address moves on the next rising edge, after the cycle has latched it.
      if (n == 0) fork begin @(posedge clk_i); chan_addr_i <= ch + 3'h1; end join_none
      if (again && n == 100) fork host.kick(); join_none
      if (n == int'(SAMPLE_PERIODS) * 2 * HALF) chk(dac_code_o, SAR_MSB, "first trial");
      s += int'(sample_o === 1'b1);
      moved |= (result_o !== prev);
      n++;
      tick();
    end
    chk(W'(n), W'(int'(CONV_PERIODS) * 2 * HALF), "cycle length");
    chk(W'(s), W'(int'(SAMPLE_PERIODS) * 2 * HALF), "sample span");
    chk(W'(moved), W'(0), "result moved while busy");
    chk(result_o, ain[ch], "result");
    chk(dac_code_o, ain[ch], "final trial");
    chk(W'(mux_chan_o), W'(ch), "latched channel");
    chk(W'(eoc_o), W'(1), "eoc at load");
    if (again) begin
      repeat (150) tick();
      chk(W'(busy_n_o), W'(1), "no extra cycle");
      chk(W'(eoc_o), W'(1), "eoc kept");
    end
    $display("test single channel %0d done", ch);
  endtask

  task automatic t_cont();
    int a;
    int b;
    @(posedge clk_i);
    chan_addr_i <= 3'h5;
    cont <= 1'b1;
    wait_busy(1'b0, a);
    wait_busy(1'b1, a);
    wait_busy(1'b0, a);
    wait_busy(1'b1, b);
    chk(W'(a + b), W'((int'(CONV_PERIODS) + 1) * 2 * HALF), "loop period");
    chk(result_o, ain[5], "loop result");
    @(posedge clk_i);
    cont <= 1'b0;
    repeat (250) tick();
    chk(W'(busy_n_o), W'(1), "loop stopped");
    $display("test continuous done");
  endtask

  task automatic t_oe();
    @(posedge clk_i);
    output_enable_i <= 1'b1;
    mux_enable_i <= 1'b0;
    repeat (6) tick();
    chk(W'(result_oe_n_o), W'(0), "bus driven");
    chk(W'(mux_en_o), W'(0), "mux off");
    @(posedge clk_i);
    output_enable_i <= 1'b0;
    mux_enable_i <= 1'b1;
    repeat (6) tick();
    chk(W'(result_oe_n_o), W'(1), "bus released");
    chk(W'(mux_en_o), W'(1), "mux on");
    $display("test output enable done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog.
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    for (int c = 0; c < 8; c++) t_single(3'(c), 1'b0);
    t_single(3'h2, 1'b1);
    t_cont();
    t_oe();
    give_verdict();
  end

  // The tests need about 2700 cycles; seven times that means a hang.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule // tb_top
